//--- verilog/dmsr_pkg.sv
// Purpose: Constants shared by the mode-two and software request block
// Assumes: Byte-wide registers at their printed offsets on a plain port
// Notes:   Offsets, bit positions and reset values live here, except the end-of-process stages, which the core resets to 1
`default_nettype none
package dmsr_pkg;
   // ==========================================
   // Register offsets
   localparam logic [15:0] DMSR_SOFT_REQ_OFS  = 16'hf009;
   localparam logic [15:0] DMSR_MODE2_OFS     = 16'hf01b;
   // ==========================================
   // Mode-two register fields
   localparam int          DMSR_M2_REQ_IO     = 6;
   localparam int          DMSR_M2_TGT_IO     = 5;
   localparam int          DMSR_M2_REQ_HOLD   = 4;
   localparam int          DMSR_M2_REQ_DIR    = 3;
   localparam int          DMSR_M2_TGT_HOLD   = 2;
   localparam int          DMSR_CH_SEL        = 0;
   // ==========================================
   // Software request register fields
   localparam int          DMSR_SR_BIT        = 2;
   // ==========================================
   // Reset values
   localparam logic [1:0]  DMSR_MODE2_RST     = 2'h0;
   localparam logic [1:0]  DMSR_PEND_RST      = 2'h0;
   localparam logic [7:0]  DMSR_RDATA_RST     = 8'h00;
   // ==========================================
   // Arbiter states
   typedef enum logic [0:0] {
      DMSR_IDLE = 1'b0,
      DMSR_BUSY = 1'b1
   } dmsr_state_t;
endpackage : dmsr_pkg
`default_nettype wire

//--- verilog/dmsr_core.sv
// Purpose: Two-channel mode-two settings, software requests, arbitration
// Assumes: Single clock, synchronous active-high reset, plain register port
// Notes:   Target direction and demand mode arrive from the first mode register
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module dmsr_core
   import dmsr_pkg::*;
#(
   parameter int AW = 26
) (
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic [15:0]         addr,
   input  wire logic [7:0]          wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic      [7:0]          rdata,
   input  wire logic [1:0]          hw_req,
   input  wire logic                end_of_process_in_n,
   input  wire logic [1:0]          tgt_dec,
   input  wire logic [1:0]          demand_mode,
   input  wire logic                xfer_strobe,
   input  wire logic                tc_in,
   input  wire logic                addr_load,
   input  wire logic                addr_load_ch,
   input  wire logic [AW-1:0]       req_addr_in,
   input  wire logic [AW-1:0]       tgt_addr_in,
   output logic      [1:0]          chan_req,
   output logic      [1:0]          grant,
   output logic      [1:0]          req_io_space,
   output logic      [1:0]          tgt_io_space,
   output logic      [1:0][AW-1:0]  req_addr,
   output logic      [1:0][AW-1:0]  tgt_addr
);
   // ==========================================
   // State
   typedef struct packed {
      logic [1:0]          req_io;
      logic [1:0]          tgt_io;
      logic [1:0]          req_hold;
      logic [1:0]          req_dec;
      logic [1:0]          tgt_hold;
      logic [1:0]          pend;
      logic [1:0]          soft_act;
      logic [1:0]          hw_s1;
      logic [1:0]          hw_s2;
      logic [1:0]          hw_s3;
      logic [1:0]          hw_f;
      logic                eop_s1;
      logic                eop_s2;
      logic                eop_s3;
      logic                eop_f;
      dmsr_state_t         state;
      logic                gch;
      logic [1:0]          grant;
      logic [1:0]          chan_req;
      logic [7:0]          rdata;
      logic [1:0][AW-1:0]  raddr;
      logic [1:0][AW-1:0]  taddr;
   } dmsr_st_t;

   dmsr_st_t           s_ff;
   dmsr_st_t           nxt_s;
   logic [1:0]         creq;
   logic               end_evt;
   logic               wr_m2;
   logic               wr_sr;
   logic               rd_sr;
   logic [AW-1:0]      one_step;

   assign one_step = {{(AW-1){1'b0}}, 1'b1};
   assign creq     = s_ff.soft_act | s_ff.hw_f;
   assign end_evt  = (s_ff.state == DMSR_BUSY) && (tc_in || !s_ff.eop_f);
   assign wr_m2    = wr && (addr == DMSR_MODE2_OFS);
   assign wr_sr    = wr && (addr == DMSR_SOFT_REQ_OFS);
   assign rd_sr    = rd && (addr == DMSR_SOFT_REQ_OFS);

   // ==========================================
   // Next state
   always_comb begin
      nxt_s        = s_ff;
      // Pin synchronisers, change taken when stages two and three agree
      nxt_s.hw_s1  = hw_req;
      nxt_s.hw_s2  = s_ff.hw_s1;
      nxt_s.hw_s3  = s_ff.hw_s2;
      nxt_s.eop_s1 = end_of_process_in_n;
      nxt_s.eop_s2 = s_ff.eop_s1;
      nxt_s.eop_s3 = s_ff.eop_s2;
      if (s_ff.eop_s2 == s_ff.eop_s3) begin
         nxt_s.eop_f = s_ff.eop_s3;
      end
      for (int i = 0; i < 2; i++) begin
         if (s_ff.hw_s2[i] == s_ff.hw_s3[i]) begin
            nxt_s.hw_f[i] = s_ff.hw_s3[i];
         end
      end
      nxt_s.chan_req = creq;
      // Arbiter, channel 0 first, no preemption
      case (s_ff.state)
         DMSR_IDLE: begin
            if (creq != 2'h0) begin
               nxt_s.state = DMSR_BUSY;
               nxt_s.gch   = !creq[0];
               nxt_s.grant = creq[0] ? 2'h1 : 2'h2;
            end
         end
         DMSR_BUSY: begin
            if (end_evt) begin
               nxt_s.soft_act[s_ff.gch] = 1'b0;
               nxt_s.state              = DMSR_IDLE;
               nxt_s.grant              = 2'h0;
            end else if (!creq[s_ff.gch]) begin
               nxt_s.state = DMSR_IDLE;
               nxt_s.grant = 2'h0;
            end
         end
         default: begin
            nxt_s.state = DMSR_IDLE;
            nxt_s.grant = 2'h0;
         end
      endcase
      // Address stepping on each data transfer of the granted channel
      if (s_ff.state == DMSR_BUSY && xfer_strobe) begin
         if (!s_ff.req_hold[s_ff.gch]) begin
            if (s_ff.req_dec[s_ff.gch]) begin
               nxt_s.raddr[s_ff.gch] = s_ff.raddr[s_ff.gch] - one_step;
            end else begin
               nxt_s.raddr[s_ff.gch] = s_ff.raddr[s_ff.gch] + one_step;
            end
         end
         if (!s_ff.tgt_hold[s_ff.gch]) begin
            if (tgt_dec[s_ff.gch]) begin
               nxt_s.taddr[s_ff.gch] = s_ff.taddr[s_ff.gch] - one_step;
            end else begin
               nxt_s.taddr[s_ff.gch] = s_ff.taddr[s_ff.gch] + one_step;
            end
         end
      end
      if (addr_load) begin
         nxt_s.raddr[addr_load_ch] = req_addr_in;
         nxt_s.taddr[addr_load_ch] = tgt_addr_in;
      end
      // Register writes
      if (wr_m2) begin
         nxt_s.req_io[wdata[DMSR_CH_SEL]]   = wdata[DMSR_M2_REQ_IO];
         nxt_s.tgt_io[wdata[DMSR_CH_SEL]]   = wdata[DMSR_M2_TGT_IO];
         nxt_s.req_hold[wdata[DMSR_CH_SEL]] = wdata[DMSR_M2_REQ_HOLD];
         nxt_s.req_dec[wdata[DMSR_CH_SEL]]  = wdata[DMSR_M2_REQ_DIR];
         nxt_s.tgt_hold[wdata[DMSR_CH_SEL]] = wdata[DMSR_M2_TGT_HOLD];
      end
      // Register read, read clears the pending flags
      nxt_s.rdata = DMSR_RDATA_RST;
      if (rd_sr) begin
         nxt_s.rdata = {6'h00, s_ff.pend};
         nxt_s.pend  = 2'h0;
      end
      // Software request, set wins over clear
      if (wr_sr && wdata[DMSR_SR_BIT]) begin
         nxt_s.pend[wdata[DMSR_CH_SEL]]     = 1'b1;
         nxt_s.soft_act[wdata[DMSR_CH_SEL]] = 1'b1;
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge clock) begin
      if (rst) begin
         s_ff          <= '0;
         s_ff.req_io   <= DMSR_MODE2_RST;
         s_ff.tgt_io   <= DMSR_MODE2_RST;
         s_ff.req_hold <= DMSR_MODE2_RST;
         s_ff.req_dec  <= DMSR_MODE2_RST;
         s_ff.tgt_hold <= DMSR_MODE2_RST;
         s_ff.pend     <= DMSR_PEND_RST;
         s_ff.rdata    <= DMSR_RDATA_RST;
         s_ff.state    <= DMSR_IDLE;
         s_ff.eop_s1   <= 1'b1;
         s_ff.eop_s2   <= 1'b1;
         s_ff.eop_s3   <= 1'b1;
         s_ff.eop_f    <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ==========================================
   // Outputs
   assign rdata        = s_ff.rdata;
   assign chan_req     = s_ff.chan_req;
   assign grant        = s_ff.grant;
   assign req_io_space = s_ff.req_io;
   assign tgt_io_space = s_ff.tgt_io;
   assign req_addr     = s_ff.raddr;
   assign tgt_addr     = s_ff.taddr;

   // ==========================================
   // Assertions
   default clocking dmsr_cb @(posedge clock); endclocking
   default disable iff (rst);

   req_space_a: assert property (wr_m2 |=>
      req_io_space[$past(wdata[DMSR_CH_SEL])] == $past(wdata[DMSR_M2_REQ_IO]))
      else $error("requester space bit not taken");
   tgt_space_a: assert property (wr_m2 |=>
      tgt_io_space[$past(wdata[DMSR_CH_SEL])] == $past(wdata[DMSR_M2_TGT_IO]))
      else $error("target space bit not taken");
   req_hold_a: assert property (
      (s_ff.state == DMSR_BUSY && xfer_strobe && !addr_load && s_ff.req_hold[s_ff.gch])
      |=> $stable(req_addr))
      else $error("held requester address moved");
   req_step_a: assert property (
      (s_ff.state == DMSR_BUSY && xfer_strobe && !addr_load && !s_ff.req_hold[s_ff.gch])
      |=> req_addr[$past(s_ff.gch)] == ($past(s_ff.req_dec[s_ff.gch])
          ? $past(req_addr[s_ff.gch]) - one_step : $past(req_addr[s_ff.gch]) + one_step))
      else $error("requester address stepped wrongly");
   tgt_step_a: assert property (
      (s_ff.state == DMSR_BUSY && xfer_strobe && !addr_load && !s_ff.tgt_hold[s_ff.gch])
      |=> tgt_addr[$past(s_ff.gch)] != $past(tgt_addr[s_ff.gch]))
      else $error("target address did not step");
   soft_set_a: assert property ((wr_sr && wdata[DMSR_SR_BIT]) |=> ##1
      chan_req[$past(wdata[DMSR_CH_SEL], 2)])
      else $error("software request not raised");
   arb_prio_a: assert property (
      (s_ff.state == DMSR_IDLE && creq == 2'h3) |=> grant == 2'h1)
      else $error("channel 0 not granted first");
   soft_keep_a: assert property (
      (s_ff.soft_act[0] && !(end_evt && !s_ff.gch)) |=> s_ff.soft_act[0])
      else $error("soft request dropped before end");
   suspend_a: assert property (
      (s_ff.state == DMSR_BUSY && !creq[s_ff.gch]) |=> grant == 2'h0)
      else $error("transfer not suspended");
   pend_read_a: assert property (rd_sr |=>
      rdata == {6'h00, $past(s_ff.pend)} && (s_ff.pend & ~$past(s_ff.pend)) == s_ff.pend)
      else $error("pending read wrong or not cleared");

   // ==========================================
   // Address behaviour checks
   tgt_hold_a: assert property (
      (s_ff.state == DMSR_BUSY && xfer_strobe && !addr_load && s_ff.tgt_hold[s_ff.gch])
      |=> $stable(tgt_addr))
      else $error("held target address moved");
   tgt_dir_a: assert property (
      (s_ff.state == DMSR_BUSY && xfer_strobe && !addr_load && !s_ff.tgt_hold[s_ff.gch])
      |=> tgt_addr[$past(s_ff.gch)] == ($past(tgt_dec[s_ff.gch])
          ? $past(tgt_addr[s_ff.gch]) - one_step : $past(tgt_addr[s_ff.gch]) + one_step))
      else $error("target address stepped the wrong way");
   hold_dir_a: assert property (
      (s_ff.state == DMSR_BUSY && xfer_strobe && !addr_load
       && s_ff.req_hold[s_ff.gch] && s_ff.req_dec[s_ff.gch]) |=> $stable(req_addr))
      else $error("direction applied under requester hold");
   idle_still_a: assert property (
      (s_ff.state == DMSR_IDLE && !addr_load) |=> ($stable(req_addr) && $stable(tgt_addr)))
      else $error("address moved while idle");

   // ==========================================
   // Request and arbitration checks
   soft_end_a: assert property (
      (end_evt && !(wr_sr && wdata[DMSR_SR_BIT] && (wdata[DMSR_CH_SEL] == s_ff.gch)))
      |=> !s_ff.soft_act[$past(s_ff.gch)])
      else $error("soft request kept after buffer end");
   pend_set_a: assert property ((wr_sr && wdata[DMSR_SR_BIT])
      |=> s_ff.pend[$past(wdata[DMSR_CH_SEL])])
      else $error("pending flag not set by request");
   grant_hot_a: assert property ($onehot0(grant))
      else $error("grant not one-hot");
   grant_req_a: assert property (
      (s_ff.state == DMSR_IDLE && creq != 2'h0) |=> grant != 2'h0)
      else $error("pending request not granted");
   chan_req_a: assert property (1'b1 |=> chan_req == $past(creq))
      else $error("channel request does not follow sources");

   // ==========================================
   // Register port checks
   rdata_idle_a: assert property (!rd_sr |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   mode_keep_a: assert property (!wr_m2
      |=> ($stable(req_io_space) && $stable(tgt_io_space)))
      else $error("space bits changed without a write");

   soft_run_c: cover property ((wr_sr && wdata[DMSR_SR_BIT]) ##[1:8] grant != 2'h0);
   dem_susp_c: cover property (s_ff.state == DMSR_BUSY && demand_mode[s_ff.gch] && !creq[s_ff.gch]);
   eop_end_c:  cover property (s_ff.state == DMSR_BUSY && !s_ff.eop_f);
   pend_rd_c:  cover property (rd_sr && s_ff.pend == 2'h3);
   hold_xfer_c: cover property (s_ff.state == DMSR_BUSY && xfer_strobe && s_ff.req_hold[s_ff.gch]);
endmodule : dmsr_core
`default_nettype wire

//--- bench/dmsr_partner.sv
// Purpose: Bus-side requester and target model
// Assumes: Grant from the block, same clock
// Notes:   Ends a transfer by count or end of process
`timescale 1ns/1ns
`default_nettype none
module dmsr_partner (
   input  wire logic       clock,
   input  wire logic [1:0] grant,
   input  wire logic [1:0] hw_on,
   input  wire logic       use_eop,
   input  wire logic [7:0] n_xfer,
   input  wire logic [7:0] gap,
   output logic      [1:0] hw_req,
   output logic            xfer_strobe,
   output logic            tc_in,
   output logic            end_of_process_in_n
);
   // ==========
   // Transfers while granted
   int k;
   assign hw_req = hw_on;
   task automatic tick;
      @(posedge clock);
      #1;
   endtask : tick
   initial begin
      xfer_strobe = 1'b0;
      tc_in = 1'b0;
      end_of_process_in_n = 1'b1;
      forever begin
         tick;
         for (k = 0; k < n_xfer && grant !== 2'h0; k++) begin
            repeat (gap) tick;
            xfer_strobe = 1'b1;
            tick;
            xfer_strobe = 1'b0;
         end
         if (k == n_xfer) begin
            if (use_eop) end_of_process_in_n = 1'b0;
            else tc_in = 1'b1;
            tick;
            tc_in = 1'b0;
            while (grant !== 2'h0) tick;
            end_of_process_in_n = 1'b1;
         end
      end
   end
endmodule : dmsr_partner
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: Self-checking bench for mode-two and soft requests
// Assumes: Plain register port, one 25 MHz clock
// Notes:   Partner model makes the transfers
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t mismatch", $time); end end
module tb_top
   import dmsr_pkg::*;
;
   logic            clock, rst, wr, rd, addr_load, use_eop, eop_n, xfer_strobe, tc_in;
   logic [15:0]     addr;
   logic [7:0]      wdata, rdata, n_xfer, gap;
   logic [1:0]      hw_req, hw_on, tgt_dec, chan_req, grant, req_io, tgt_io;
   logic [25:0]     rin, tin;
   logic [1:0][25:0] req_addr, tgt_addr;
   int              failures, samples_checked, i, w;
   logic [7:0]      mode [4] = '{8'h00, 8'h08, 8'h1c, 8'h64};
   int              rdl [4] = '{1, -1, 0, 1};
   int              tdl [4] = '{1, -1, 0, 0};
   dmsr_core u_dmsr_core (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .hw_req(hw_req), .end_of_process_in_n(eop_n), .tgt_dec(tgt_dec),
      .demand_mode(2'h0), .xfer_strobe(xfer_strobe), .tc_in(tc_in), .addr_load(addr_load),
      .addr_load_ch(i[0]), .req_addr_in(rin), .tgt_addr_in(tin), .chan_req(chan_req),
      .grant(grant), .req_io_space(req_io), .tgt_io_space(tgt_io), .req_addr(req_addr),
      .tgt_addr(tgt_addr));
   dmsr_partner u_dmsr_partner (.clock(clock), .grant(grant), .hw_on(hw_on), .use_eop(use_eop),
      .n_xfer(n_xfer), .gap(gap), .hw_req(hw_req), .xfer_strobe(xfer_strobe), .tc_in(tc_in),
      .end_of_process_in_n(eop_n));
   // ==========
   // Bus tasks
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clock);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd_reg
   task automatic wait_grant(input logic [1:0] e);
      w = 0;
      while (grant !== e && w < 300) begin
         @(posedge clock);
         #1;
         w++;
      end
      `CHK(grant, e)
   endtask : wait_grant
   task automatic stop_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   // ==========
   // Clock, watchdog, tests
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      stop_test;
   end
   initial begin
      {rst, wr, rd, addr, wdata, addr_load, use_eop, hw_on, tgt_dec, rin, tin} = '0;
      rst = 1'b1;
      i = 0;
      n_xfer = 8'd3;
      gap = 8'd0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      `CHK({grant, chan_req, req_io, rdata}, 14'h0)
      wr_reg(16'hf00a, 8'h05);
      rd_reg(DMSR_MODE2_OFS, 8'h00);
      rd_reg(16'h1234, 8'h00);
      rd_reg(DMSR_SOFT_REQ_OFS, 8'h00);
      for (i = 0; i < 4; i++) begin
         @(posedge clock);
         tgt_dec <= {2{i[0]}};
         use_eop <= (i == 3);
         gap <= 8'(4 + i);
         addr_load <= 1'b1;
         rin <= 26'd100;
         tin <= 26'd500;
         @(posedge clock);
         addr_load <= 1'b0;
         wr_reg(DMSR_MODE2_OFS, mode[i] | 8'(i[0]));
         `CHK(req_io, {mode[i][6] & i[0], mode[i][6] & ~i[0]})
         `CHK(tgt_io, {mode[i][5] & i[0], mode[i][5] & ~i[0]})
         wr_reg(DMSR_SOFT_REQ_OFS, 8'h04 | 8'(i[0]));
         rd_reg(DMSR_SOFT_REQ_OFS, 8'h01 << i[0]);
         rd_reg(DMSR_SOFT_REQ_OFS, 8'h00);
         wait_grant(2'h1 << i[0]);
         `CHK(chan_req[i[0]], 1'b1)
         wait_grant(2'h0);
         `CHK(req_addr[i[0]], 26'(100 + 3 * rdl[i]))
         `CHK(tgt_addr[i[0]], 26'(500 + 3 * tdl[i]))
         repeat (4) @(posedge clock);
         #1;
         `CHK(chan_req, 2'h0)
      end
      @(posedge clock);
      n_xfer <= 8'd200;
      gap <= 8'd1;
      hw_on <= 2'h3;
      wait_grant(2'h1);
      @(posedge clock);
      hw_on <= 2'h2;
      wait_grant(2'h0);
      wait_grant(2'h2);
      @(posedge clock);
      hw_on <= 2'h0;
      wait_grant(2'h0);
      stop_test;
   end
endmodule : tb_top
`default_nettype wire
